// ### hw/psc_pkg.sv
// Constants, types and register map of the pluggable module sideband controller.
// ============================================================================
// Operation
// (R1) Select low: answer management bus commands.
// (R2) Select high: ignore every management transaction.
// (R3) Undriven select defaults to deselected (high).
// (R4) Long reset low restores all settings.
// (R5) Init interval starts at reset rising edge.
// (R6) Host ignores status until reset completes.
// (R7) Reset done: interrupt with not-ready cleared.
// (R8) Power-up posts reset-done interrupt unasked.
// (R9) Low-power input high enters reduced power.
// (R10) Presence output low while module inserted.
// (R11) Interrupt low flags fault or critical status.
// (R12) Host reads management bus for cause.
// (R13) Interrupt pin only pulls low, never high.
// (R14) Host reads flag field after interrupt.
// (R15) Host holds select low whole transaction.
// (R16) Synchronise select, reset, low-power inputs first.
package psc_pkg;

  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Least low time on the reset pin that counts as a reset request.
  localparam int unsigned RESET_MIN_NS = 10000;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Length of the reset initialisation interval.
  localparam int unsigned INIT_NS = 2000000;
  localparam int unsigned INIT_CYC_DEF = INIT_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte addresses.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_LIVE = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADR_IRQ_EN = 8'h10;

  // Control register fields and reset value.
  localparam int unsigned CTRL_W = 2;
  localparam int unsigned CTRL_FORCE_LP = 0;
  localparam int unsigned CTRL_SOFT_RST = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

  // Interrupt event bits; status, clear and enable share this layout.
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_RESET_DONE = 0;
  localparam int unsigned EV_FAULT = 1;
  localparam int unsigned EV_CRITICAL = 2;
  localparam int unsigned EV_LP_CHANGE = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h7;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 4'h0;

  // Synchronised sideband pins.
  typedef struct packed {
    logic sel_n;
    logic rst_n;
    logic lpm;
    logic scl;
    logic sda;
  } psc_pins_t;
  localparam psc_pins_t PINS_RST = '{sel_n: 1'b1, rst_n: 1'b1, lpm: 1'b0, scl: 1'b1, sda: 1'b1};

  // Live status word as read by software.
  typedef struct packed {
    logic [26:0] zero;
    logic low_power;
    logic data_not_ready;
    logic lpm_pin;
    logic reset_pin_n;
    logic selected;
  } psc_live_t;

  // Reset sequencer states, Gray coded along run, pin low, init; init back to run changes both bits.
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_PIN_LOW = 2'b01,
    ST_INIT = 2'b11
  } psc_state_t;

endpackage

// ### hw/psc_sideband_ctrl.sv
// Sideband control and status logic of a four-lane pluggable cable module.
`timescale 1ns/1ps

module psc_sideband_ctrl import psc_pkg::*; #(
  parameter int unsigned INIT_CYC = INIT_CYC_DEF
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host sideband pins.
  input wire logic module_select_n_pin_i,
  input wire logic module_select_drv_i,
  input wire logic module_reset_n_i,
  input wire logic low_power_request_i,
  output logic module_present_n_o,
  input wire logic attention_irq_n_i,
  output logic attention_irq_n_o,
  output logic attention_irq_n_oe_n_o,
  // Shared two-wire management bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Internal management responder side.
  output logic mgmt_scl_o,
  output logic mgmt_sda_o,
  input wire logic mgmt_sda_pull_i,
  // Module core side.
  input wire logic fault_event_i,
  input wire logic critical_event_i,
  output logic core_reset_o,
  output logic low_power_o,
  output logic data_not_ready_o,
  output logic irq_o
);

  // ==========================================================================
  // Pin synchronisers.

  // An undriven select pin reads as deselected, as its pull-up would make it.
  wire logic sel_pin_eff = module_select_drv_i ? module_select_n_pin_i : 1'b1; // R3
  wire psc_pins_t pins_raw = '{sel_n: sel_pin_eff, rst_n: module_reset_n_i,
                               lpm: low_power_request_i, scl: scl_i, sda: sda_i};

  psc_pins_t meta_r;
  psc_pins_t sync_r;

  // Two flip-flops per pin; only the second stage is used anywhere.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= PINS_RST;
      sync_r <= PINS_RST;
    end else begin
      meta_r <= pins_raw; // R16
      sync_r <= meta_r; // R16
    end
  end

  wire logic selected = ~sync_r.sel_n;

  // ==========================================================================
  // Reset sequencer.

  psc_state_t state_r;
  psc_state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic rst_pin_d_r;
  logic soft_rst;

  wire logic pin_low = ~sync_r.rst_n;
  wire logic pin_rise = sync_r.rst_n & ~rst_pin_d_r;
  wire logic long_enough = (cnt_r >= RESET_MIN_CYC - 1);
  wire logic init_last = (cnt_r >= INIT_CYC - 1);

  // Next state: a low pulse is timed, and only a long enough one starts init.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_RUN: begin
        cnt_nxt = 32'h0000_0000;
        if (soft_rst) begin
          state_nxt = ST_INIT;
        end else if (pin_low) begin
          state_nxt = ST_PIN_LOW;
        end
      end
      ST_PIN_LOW: begin
        if (sync_r.rst_n) begin
          cnt_nxt = 32'h0000_0000;
          // Short glitches return to run, cutting short any init in progress; long pulses start init at the rising edge.
          state_nxt = (long_enough && pin_rise) ? ST_INIT : ST_RUN; // R4 R5
        end else if (!long_enough) begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      ST_INIT: begin
        if (pin_low) begin
          cnt_nxt = 32'h0000_0000;
          state_nxt = ST_PIN_LOW;
        end else if (init_last) begin
          cnt_nxt = 32'h0000_0000;
          state_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      default: begin
        cnt_nxt = 32'h0000_0000;
        state_nxt = ST_INIT;
      end
    endcase
  end

  // Power-up enters the init interval just as a pin reset does.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_INIT; // R8
      cnt_r <= 32'h0000_0000;
      rst_pin_d_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rst_pin_d_r <= sync_r.rst_n;
    end
  end

  // Settings are held at defaults while the module is in reset.
  wire logic in_reset = (state_r == ST_INIT) ||
                        ((state_r == ST_PIN_LOW) && long_enough); // R4
  wire logic init_done = (state_r == ST_INIT) && (state_nxt == ST_RUN); // R7 R8

  // ==========================================================================
  // Wishbone register file.

  logic [CTRL_W-1:0] ctrl_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic lpm_d_r;

  wire logic wb_req = wb_cyc_i & wb_stb_i;
  wire logic wr_now = wb_req & wb_we_i & ack_r & wb_sel_i[0];
  wire logic wr_ctrl = wr_now && (wb_adr_i == ADR_CTRL);
  wire logic wr_clr = wr_now && (wb_adr_i == ADR_IRQ_CLR);
  wire logic wr_en = wr_now && (wb_adr_i == ADR_IRQ_EN);
  assign soft_rst = ctrl_r[CTRL_SOFT_RST];

  wire logic low_power = sync_r.lpm | ctrl_r[CTRL_FORCE_LP]; // R9
  wire psc_live_t live = '{zero: 27'h0, low_power: low_power,
                           data_not_ready: in_reset, lpm_pin: sync_r.lpm,
                           reset_pin_n: sync_r.rst_n, selected: selected};

  // Read multiplexer; unmapped and write-only addresses read as zero.
  wire logic [31:0] rdat = (wb_adr_i == ADR_CTRL) ? {30'h0, ctrl_r} :
                           (wb_adr_i == ADR_LIVE) ? live :
                           (wb_adr_i == ADR_IRQ_STAT) ? {28'h0, irq_stat_r} :
                           (wb_adr_i == ADR_IRQ_EN) ? {28'h0, irq_en_r} :
                           32'h0000_0000;

  // Events that set sticky status bits.
  wire logic lp_change = sync_r.lpm ^ lpm_d_r;
  wire logic [IRQ_W-1:0] events = {lp_change, critical_event_i & ~in_reset,
                                   fault_event_i & ~in_reset, init_done};
  wire logic [IRQ_W-1:0] clr_mask = wr_clr ? wb_dat_i[IRQ_W-1:0] : 4'h0;
  // A set in the same cycle as its clear wins.
  wire logic [IRQ_W-1:0] stat_nxt = (irq_stat_r & ~clr_mask) | events; // R7 R11

  // Bus handshake: one ack per request, dropped in the cycle after it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req & ~ack_r;
      rdat_r <= rdat;
    end
  end

  // Control and enable registers return to defaults on any module reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      irq_en_r <= IRQ_EN_RST;
    end else if (in_reset) begin
      ctrl_r <= CTRL_RST; // R4
      irq_en_r <= IRQ_EN_RST; // R4
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wb_dat_i[CTRL_W-1:0];
      end
      if (wr_en) begin
        irq_en_r <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // Sticky status; cleared by reset so only the completion bit and a low-power change in the last init cycle survive init.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= IRQ_STAT_RST;
      lpm_d_r <= 1'b0;
    end else begin
      irq_stat_r <= (in_reset && !init_done) ? IRQ_STAT_RST : stat_nxt;
      lpm_d_r <= sync_r.lpm;
    end
  end

  wire logic irq_level = |(stat_nxt & irq_en_r) && !(in_reset && !init_done);

  // ==========================================================================
  // Management bus gating and sideband outputs.

  // Deselected: the responder sees an idle bus and never pulls data low.
  wire logic mgmt_scl = selected ? sync_r.scl : 1'b1; // R1 R2
  wire logic mgmt_sda = selected ? sync_r.sda : 1'b1; // R1 R2
  wire logic sda_drive = selected & mgmt_sda_pull_i; // R1 R2

  // Every output comes from a flip-flop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      module_present_n_o <= 1'b0;
      attention_irq_n_o <= 1'b0;
      attention_irq_n_oe_n_o <= 1'b1;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      mgmt_scl_o <= 1'b1;
      mgmt_sda_o <= 1'b1;
      core_reset_o <= 1'b1;
      low_power_o <= 1'b0;
      data_not_ready_o <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      wb_dat_o <= rdat;
      wb_ack_o <= wb_req & ~ack_r;
      module_present_n_o <= 1'b0; // R10
      attention_irq_n_o <= 1'b0; // R13
      attention_irq_n_oe_n_o <= ~irq_level; // R11 R13
      sda_o <= 1'b0;
      sda_oe_n_o <= ~sda_drive; // R2
      mgmt_scl_o <= mgmt_scl;
      mgmt_sda_o <= mgmt_sda;
      core_reset_o <= in_reset; // R4
      low_power_o <= low_power; // R9
      data_not_ready_o <= in_reset && !init_done; // R7
      irq_o <= irq_level;
    end
  end

endmodule // psc_sideband_ctrl

// ### tb/psc_host_model.sv
// Host board model: pull-ups and open-drain wiring of the sideband pins.
`timescale 1ns/1ps
// ============================================================================
// Host model.
module psc_host_model (
  // Host controls.
  input wire logic scl_low_i,
  input wire logic sda_low_i,
  // Module pin drivers.
  input wire logic sda_oe_n_i,
  input wire logic irq_oe_n_i,
  // Resolved wire levels.
  output logic scl_o,
  output logic sda_o,
  output logic irq_n_o
);
  // Pull-ups hold each line high unless some party pulls it low.
  assign scl_o = ~scl_low_i;
  assign sda_o = ~(sda_low_i | ~sda_oe_n_i);
  assign irq_n_o = irq_oe_n_i;
endmodule // psc_host_model

// ### tb/psc_sideband_ctrl_chk.sv
// Concurrent checks on the sideband controller ports.
`timescale 1ns/1ps
// ============================================================================
// Checker.
module psc_sideband_ctrl_chk #(
  parameter int INIT_CYC = 20
) (
  // Watched ports.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic module_select_n_pin_i,
  input wire logic module_select_drv_i,
  input wire logic module_reset_n_i,
  input wire logic scl_i,
  input wire logic module_present_n_o,
  input wire logic attention_irq_n_o,
  input wire logic attention_irq_n_oe_n_o,
  input wire logic sda_oe_n_o,
  input wire logic mgmt_scl_o,
  input wire logic core_reset_o,
  input wire logic data_not_ready_o,
  input wire logic irq_o
);
  localparam int INIT_HI = INIT_CYC + 8;
  logic [10:0] low_cnt_r;
  logic [31:0] nr_cnt_r;
  // Counts cycles of reset pin low and of the not-ready flag high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt_r <= 11'h000;
      nr_cnt_r <= 32'h0;
    end else begin
      low_cnt_r <= module_reset_n_i ? 11'h000 : low_cnt_r + {10'h000, ~&low_cnt_r};
      nr_cnt_r <= data_not_ready_o ? nr_cnt_r + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_present; module_present_n_o == 1'b0; endproperty
  a_present: assert property (p_present)
    else $error("presence not low");
  property p_no_high; attention_irq_n_o == 1'b0; endproperty
  a_no_high: assert property (p_no_high)
    else $error("irq pin drives high");
  property p_irq_pin; attention_irq_n_oe_n_o == !irq_o; endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("irq pin differs from irq");
  property p_desel;
    (!module_select_drv_i || module_select_n_pin_i) [*4] |-> mgmt_scl_o && sda_oe_n_o;
  endproperty
  a_desel: assert property (p_desel)
    else $error("bus passed while deselected");
  property p_sel;
    (module_select_drv_i && !module_select_n_pin_i) [*6] |-> mgmt_scl_o == $past(scl_i, 3);
  endproperty
  a_sel: assert property (p_sel)
    else $error("bus not passed while selected");
  property p_long_rst; $rose(core_reset_o) |-> low_cnt_r >= 11'h3E8; endproperty
  a_long_rst: assert property (p_long_rst)
    else $error("reset on short pulse");
  property p_init_len; $fell(data_not_ready_o) |-> nr_cnt_r >= INIT_CYC; endproperty
  a_init_len: assert property (p_init_len)
    else $error("init too short");
  property p_init_end;
    $rose(module_reset_n_i) && core_reset_o |-> ##[1:INIT_HI] !data_not_ready_o;
  endproperty
  a_init_end: assert property (p_init_end)
    else $error("init too long");
  property p_done; $fell(data_not_ready_o) |-> ##[0:2] irq_o; endproperty
  a_done: assert property (p_done)
    else $error("no reset done irq");
  property p_boot; $fell(rst_i) |-> ##[1:INIT_HI] irq_o; endproperty
  a_boot: assert property (p_boot)
    else $error("no power-up irq");
  c_init: cover property ($fell(data_not_ready_o));
  c_rst: cover property ($rose(core_reset_o));
  c_irq: cover property ($rose(irq_o));
endmodule // psc_sideband_ctrl_chk
bind psc_sideband_ctrl psc_sideband_ctrl_chk #(.INIT_CYC(INIT_CYC)) psc_sideband_ctrl_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .module_select_n_pin_i(module_select_n_pin_i),
  .module_select_drv_i(module_select_drv_i), .module_reset_n_i(module_reset_n_i),
  .scl_i(scl_i), .module_present_n_o(module_present_n_o), .irq_o(irq_o),
  .attention_irq_n_o(attention_irq_n_o), .attention_irq_n_oe_n_o(attention_irq_n_oe_n_o),
  .sda_oe_n_o(sda_oe_n_o), .mgmt_scl_o(mgmt_scl_o), .core_reset_o(core_reset_o),
  .data_not_ready_o(data_not_ready_o));

// ### tb/psc_sideband_ctrl_bench.sv
// Self-checking bench of the sideband controller.
`timescale 1ns/1ps
// ============================================================================
// Bench.
module psc_sideband_ctrl_bench import psc_pkg::*;;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, lp, nrdy, irq, core_rst;
  logic sel_n = 1'b1, sel_drv = 1'b0, rst_n = 1'b1, lpm = 1'b0, fault = 1'b0, crit = 1'b0;
  logic scl_low = 1'b0, pull = 1'b0, scl, sda, irq_w, irq_oe_n, sda_oe_n, mscl, prs_n;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0, dat_r, rd;
  int num_errors = 0, checked = 0, cyc_cnt = 0;
  // Clock.
  initial forever #5 clk_i = ~clk_i;
  // Device and host board.
  psc_sideband_ctrl #(.INIT_CYC(20)) psc_sideband_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .module_select_n_pin_i(sel_n), .module_select_drv_i(sel_drv), .module_reset_n_i(rst_n),
    .low_power_request_i(lpm), .module_present_n_o(prs_n), .attention_irq_n_i(irq_w),
    .attention_irq_n_o(), .attention_irq_n_oe_n_o(irq_oe_n), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_n_o(sda_oe_n), .mgmt_scl_o(mscl), .mgmt_sda_o(), .mgmt_sda_pull_i(pull),
    .fault_event_i(fault), .critical_event_i(crit), .core_reset_o(core_rst), .low_power_o(lp),
    .data_not_ready_o(nrdy), .irq_o(irq));
  psc_host_model psc_host_model_inst (.scl_low_i(scl_low), .sda_low_i(1'b0),
    .sda_oe_n_i(sda_oe_n), .irq_oe_n_i(irq_oe_n), .scl_o(scl), .sda_o(sda), .irq_n_o(irq_w));
  // Compares one value and counts it.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic bus cycle; read data lands in rd.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  // Waits, bounded, until the init interval ends.
  task automatic wait_ready();
    for (int i = 0; i < 100 && nrdy !== 1'b0; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    check("ready", 32'h0, nrdy);
  endtask
  // Power-up completion, clearing, read-only and unmapped places.
  task automatic t_boot();
    wait_ready();
    check("irq pin", 32'h0, irq_w);
    check("present", 32'h0, prs_n);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check("stat", 32'h1, rd);
    wb(1'b0, ADR_IRQ_EN, 32'h0);
    check("enable", {28'h0, IRQ_EN_RST}, rd);
    wb(1'b1, ADR_IRQ_CLR, 32'h1);
    wb(1'b1, ADR_IRQ_STAT, 32'hF);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check("cleared", 32'h0, rd);
    wb(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h0, rd);
    check("irq off", 32'h1, irq_w);
    $display("test boot done");
  endtask
  // Selected, deselected and undriven select.
  task automatic t_select();
    logic [1:0] mode [3] = '{2'b10, 2'b11, 2'b00};
    scl_low <= 1'b1;
    pull <= 1'b1;
    foreach (mode[i]) begin
      sel_drv <= mode[i][1];
      sel_n <= mode[i][0];
      repeat (6) @(posedge clk_i);
      check("bus scl", mode[i] != 2'b10, mscl);
      check("bus sda", mode[i] != 2'b10, sda_oe_n);
    end
    scl_low <= 1'b0;
    pull <= 1'b0;
    $display("test select done");
  endtask
  // Events, masking, low power.
  task automatic t_events();
    fault <= 1'b1;
    crit <= 1'b1;
    lpm <= 1'b1;
    @(posedge clk_i);
    fault <= 1'b0;
    crit <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("lp", 32'h1, lp);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check("events", 32'hE, rd);
    lpm <= 1'b0;
    wb(1'b1, ADR_IRQ_EN, 32'h0);
    wb(1'b1, ADR_IRQ_CLR, 32'hF);
    fault <= 1'b1;
    @(posedge clk_i);
    fault <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("masked", 32'h0, irq);
    wb(1'b1, ADR_IRQ_EN, 32'hF);
    repeat (2) @(posedge clk_i);
    check("pending", 32'h1, irq);
    wb(1'b1, ADR_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    check("forced lp", 32'h1, lp);
    $display("test events done");
  endtask
  // Short pulse ignored; long pulse resets and restores defaults.
  task automatic t_pin_reset();
    rst_n <= 1'b0;
    repeat (100) @(posedge clk_i);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    check("short", 32'h0, core_rst);
    rst_n <= 1'b0;
    repeat (RESET_MIN_CYC + 10) @(posedge clk_i);
    check("long", 32'h1, core_rst);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    check("init", 32'h1, nrdy);
    wait_ready();
    check("done irq", 32'h1, irq);
    wb(1'b0, ADR_IRQ_EN, 32'h0);
    check("default", {28'h0, IRQ_EN_RST}, rd);
    wb(1'b0, ADR_CTRL, 32'h0);
    check("ctrl", 32'h0, rd);
    $display("test pin reset done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_boot();
    t_select();
    t_events();
    t_pin_reset();
    print_verdict();
  end
endmodule // psc_sideband_ctrl_bench
